//--- design/vtr_ahb_capture.sv
`timescale 1ns/1ps
module vtr_ahb_capture
  import vtr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_slave_select,
  input  wire logic        i_htrans1,
  input  wire logic        i_hreadyin,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hprot1,
  input  wire logic [11:2] i_haddr,
  output vtr_phase_t       o_phase
);
  vtr_phase_t phase_ff;
  vtr_phase_t nxt_phase;
  logic       take;

  assign take = vtr_take(i_slave_select, i_htrans1, i_hreadyin);

  always_comb begin
    nxt_phase       = '0;
    nxt_phase.valid = take;
    nxt_phase.write = i_hwrite;
    nxt_phase.idx   = i_haddr;
    nxt_phase.bad   = !vtr_mapped(i_haddr) || i_hsize != HSIZE_WORD ||
                      (i_hwrite && !i_hprot1 && i_haddr == vtr_idx(OFF_TEST_CTRL));
  end

  // The phase is held while another slave stretches its data phase.
  // Ready input gates.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_ff <= '0;
    end else if (i_hreadyin) begin
      phase_ff <= nxt_phase;
    end
  end

  assign o_phase = phase_ff;
endmodule

//--- design/vtr_test_readback.sv
`timescale 1ns/1ps
module vtr_test_readback
  import vtr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_slave_select,
  input  wire logic        i_htrans1,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic        i_hprot1,
  input  wire logic [11:2] i_haddr,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hreadyin,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic      [1:0]  o_hresp,
  input  wire logic        i_chained_irq_in_n,
  input  wire logic        i_chained_fiq_in_n,
  input  wire logic [31:0] i_chained_vector_address_in,
  input  wire logic        i_internal_irq_request,
  input  wire logic        i_internal_fiq_request,
  input  wire logic [31:0] i_vector_address_next,
  output logic             o_irq_request_out_n,
  output logic             o_fiq_request_out_n,
  output logic      [31:0] o_vector_address_out,
  output logic             o_integration_test_enable
);
  vtr_phase_t      phase;
  vtr_resp_state_t state_ff;
  vtr_resp_state_t nxt_state;
  vtr_chain_t      live;
  vtr_chain_t      snap_ff;
  vtr_chain_t      seen;
  logic            take;
  logic            take_bad;
  logic            ten_ff;
  logic            hreadyout_ff;
  logic [1:0]      hresp_ff;
  logic [31:0]     hrdata_ff;
  logic [31:0]     nxt_rdata;
  logic            irq_n_ff;
  logic            fiq_n_ff;
  logic [31:0]     vec_out_ff;
  logic            ctrl_wr;

  vtr_ahb_capture u_capture (
    .i_clk          (i_clk),
    .i_rst_n        (i_rst_n),
    .i_slave_select (i_slave_select),
    .i_htrans1      (i_htrans1),
    .i_hreadyin     (i_hreadyin),
    .i_hwrite       (i_hwrite),
    .i_hsize        (i_hsize),
    .i_hprot1       (i_hprot1),
    .i_haddr        (i_haddr),
    .o_phase        (phase)
  );

  assign take = vtr_take(i_slave_select, i_htrans1, i_hreadyin);
  // Bad accesses take the same decode as the capture stage so both agree.
  assign take_bad = take && (!vtr_mapped(i_haddr) || i_hsize != HSIZE_WORD ||
                    (i_hwrite && !i_hprot1 && i_haddr == vtr_idx(OFF_TEST_CTRL)));

  // Control write lands at the end of its single-cycle OKAY data phase.
  // Only control writes.
  assign ctrl_wr = phase.valid && phase.write && !phase.bad &&
                   phase.idx == vtr_idx(OFF_TEST_CTRL);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ten_ff <= TEST_EN_RST;
    end else if (ctrl_wr) begin
      ten_ff <= i_hwdata[TEST_EN_BIT];
    end
  end

  assign live.irq_n = i_chained_irq_in_n;
  assign live.fiq_n = i_chained_fiq_in_n;
  assign live.vec   = i_chained_vector_address_in;

  // In test mode the input view is frozen, so software reads a stable
  // picture of the chain even while the neighbour keeps toggling.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      snap_ff <= '0;
    end else if (!ten_ff) begin
      snap_ff <= live;
    end
  end

  assign seen = ten_ff ? snap_ff : live;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_n_ff   <= REQ_N_RST;
      fiq_n_ff   <= REQ_N_RST;
      vec_out_ff <= WORD_RST;
    end else begin
      irq_n_ff   <= !i_internal_irq_request;
      fiq_n_ff   <= !i_internal_fiq_request;
      vec_out_ff <= i_vector_address_next;
    end
  end

  // Undefined bits read as zero.
  // Word index decode.
  always_comb begin
    nxt_rdata = WORD_RST;
    unique case (i_haddr)
      vtr_idx(OFF_TEST_CTRL): begin
        nxt_rdata[TEST_EN_BIT] = ten_ff;
      end
      vtr_idx(OFF_CHAIN_IN_RB): begin
        nxt_rdata[IRQ_BIT] = seen.irq_n;
        nxt_rdata[FIQ_BIT] = seen.fiq_n;
      end
      vtr_idx(OFF_VEC_IN_RB): begin
        nxt_rdata = seen.vec;
      end
      vtr_idx(OFF_REQ_OUT_RB): begin
        nxt_rdata[IRQ_BIT] = !irq_n_ff;
        nxt_rdata[FIQ_BIT] = !fiq_n_ff;
      end
      vtr_idx(OFF_VEC_OUT_RB): begin
        nxt_rdata = vec_out_ff;
      end
      default: begin
        nxt_rdata = WORD_RST;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hrdata_ff <= WORD_RST;
    end else if (take && !i_hwrite && !take_bad) begin
      hrdata_ff <= nxt_rdata;
    end else if (take) begin
      hrdata_ff <= WORD_RST;
    end
  end

  // ERROR is two cycles: first with ready low so the master can cancel.
  always_comb begin
    nxt_state = VTR_OK;
    unique case (state_ff)
      VTR_OK: begin
        nxt_state = take_bad ? VTR_ERR_WAIT : VTR_OK;
      end
      VTR_ERR_WAIT: begin
        nxt_state = VTR_ERR_LAST;
      end
      VTR_ERR_LAST: begin
        nxt_state = take_bad ? VTR_ERR_WAIT : VTR_OK;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= VTR_OK;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hreadyout_ff <= 1'h1;
    end else begin
      hreadyout_ff <= nxt_state != VTR_ERR_WAIT;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hresp_ff <= HRESP_OKAY;
    end else begin
      hresp_ff <= (nxt_state == VTR_OK) ? HRESP_OKAY : HRESP_ERROR;
    end
  end

  assign o_hrdata                  = hrdata_ff;
  assign o_hreadyout               = hreadyout_ff;
  assign o_hresp                   = hresp_ff;
  assign o_irq_request_out_n       = irq_n_ff;
  assign o_fiq_request_out_n       = fiq_n_ff;
  assign o_vector_address_out      = vec_out_ff;
  assign o_integration_test_enable = ten_ff;

  sequence s_rd_take(logic [11:0] off);
    take && !i_hwrite && !take_bad && i_haddr == vtr_idx(off);
  endsequence

  sequence s_bad_take;
    take_bad && state_ff != VTR_ERR_WAIT;
  endsequence

  sequence s_err_answer;
    (!o_hreadyout && o_hresp == HRESP_ERROR) ##1 (o_hreadyout && o_hresp == HRESP_ERROR);
  endsequence

  property p_chain_in_bits;
    @(posedge i_clk) disable iff (!i_rst_n)
    (s_rd_take(OFF_CHAIN_IN_RB) ##0 !ten_ff) |=>
      o_hrdata[IRQ_BIT] == $past(i_chained_irq_in_n) &&
      o_hrdata[FIQ_BIT] == $past(i_chained_fiq_in_n) &&
      o_hrdata[5:0] == 6'h0 && o_hrdata[31:8] == 24'h0;
  endproperty
  a_chain_in_bits: assert property (p_chain_in_bits)
    else $error("Chained input readback mismatch.");

  property p_vec_in_word;
    @(posedge i_clk) disable iff (!i_rst_n)
    (s_rd_take(OFF_VEC_IN_RB) ##0 !ten_ff) |=>
      o_hrdata == $past(i_chained_vector_address_in);
  endproperty
  a_vec_in_word: assert property (p_vec_in_word)
    else $error("Chained vector readback mismatch.");

  property p_req_out_bits;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_rd_take(OFF_REQ_OUT_RB) |=>
      o_hrdata[IRQ_BIT] == !$past(o_irq_request_out_n) &&
      o_hrdata[FIQ_BIT] == !$past(o_fiq_request_out_n);
  endproperty
  a_req_out_bits: assert property (p_req_out_bits)
    else $error("Request output readback mismatch.");

  property p_req_invert;
    @(posedge i_clk) disable iff (!i_rst_n)
    ##1 (o_irq_request_out_n == !$past(i_internal_irq_request) &&
         o_fiq_request_out_n == !$past(i_internal_fiq_request));
  endproperty
  a_req_invert: assert property (p_req_invert)
    else $error("Request outputs are not the inverted requests.");

  property p_vec_out_word;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_rd_take(OFF_VEC_OUT_RB) |=> o_hrdata == $past(o_vector_address_out);
  endproperty
  a_vec_out_word: assert property (p_vec_out_word)
    else $error("Vector output readback mismatch.");

  property p_ro_write_okay;
    @(posedge i_clk) disable iff (!i_rst_n)
    (take && i_hwrite && !take_bad && i_haddr != vtr_idx(OFF_TEST_CTRL)) |=>
      (o_hreadyout && o_hresp == HRESP_OKAY) ##1 $stable(ten_ff);
  endproperty
  a_ro_write_okay: assert property (p_ro_write_okay)
    else $error("Read-only write did not complete OKAY without effect.");

  property p_resp_legal;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_hresp == HRESP_OKAY || o_hresp == HRESP_ERROR;
  endproperty
  a_resp_legal: assert property (p_resp_legal)
    else $error("Response is neither OKAY nor ERROR.");

  property p_err_two_cycle;
    @(posedge i_clk) disable iff (!i_rst_n)
    s_bad_take |=> s_err_answer;
  endproperty
  a_err_two_cycle: assert property (p_err_two_cycle)
    else $error("ERROR answer is not the two-cycle form.");

  property p_ctrl_write;
    @(posedge i_clk) disable iff (!i_rst_n)
    (take && i_hwrite && !take_bad && i_haddr == vtr_idx(OFF_TEST_CTRL)) |=>
      ##1 ten_ff == $past(i_hwdata[TEST_EN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("Test enable did not take the written bit.");

  property p_idle_okay;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!(i_slave_select && i_htrans1) && i_hreadyin && state_ff != VTR_ERR_WAIT) |=>
      o_hreadyout && o_hresp == HRESP_OKAY;
  endproperty
  a_idle_okay: assert property (p_idle_okay)
    else $error("Unselected or idle transfer got a non-OKAY answer.");

  property p_hold_when_busy;
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_hreadyin |=> $stable(phase);
  endproperty
  a_hold_when_busy: assert property (p_hold_when_busy)
    else $error("Captured phase moved while the bus was stretched.");

  property p_freeze;
    @(posedge i_clk) disable iff (!i_rst_n)
    (ten_ff && $past(ten_ff)) |-> $stable(snap_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("Input snapshot changed in test mode.");

  property p_rdata_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    !take |=> $stable(o_hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data moved without a new transfer.");

  property p_vec_follow;
    @(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_vector_address_out == $past(i_vector_address_next);
  endproperty
  a_vec_follow: assert property (p_vec_follow)
    else $error("Vector output does not follow the core vector.");

  property p_wait_once;
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_hreadyout |=> o_hreadyout;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("Ready stayed low for more than one cycle.");

  property p_chain_in_frozen;
    @(posedge i_clk) disable iff (!i_rst_n)
    (s_rd_take(OFF_CHAIN_IN_RB) ##0 ten_ff) |=>
      o_hrdata[IRQ_BIT] == $past(snap_ff.irq_n) &&
      o_hrdata[FIQ_BIT] == $past(snap_ff.fiq_n);
  endproperty
  a_chain_in_frozen: assert property (p_chain_in_frozen)
    else $error("Chained input readback left the snapshot in test mode.");

  property p_vec_in_frozen;
    @(posedge i_clk) disable iff (!i_rst_n)
    (s_rd_take(OFF_VEC_IN_RB) ##0 ten_ff) |=> o_hrdata == $past(snap_ff.vec);
  endproperty
  a_vec_in_frozen: assert property (p_vec_in_frozen)
    else $error("Chained vector readback left the snapshot in test mode.");

  property p_user_ctrl_write;
    @(posedge i_clk) disable iff (!i_rst_n)
    (take && i_hwrite && !i_hprot1 && i_haddr == vtr_idx(OFF_TEST_CTRL)) |=>
      ##1 $stable(ten_ff);
  endproperty
  a_user_ctrl_write: assert property (p_user_ctrl_write)
    else $error("User-mode control write changed the test enable.");

  property p_idle_no_effect;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!(i_slave_select && i_htrans1) && i_hreadyin) |=> ##1 $stable(ten_ff);
  endproperty
  a_idle_no_effect: assert property (p_idle_no_effect)
    else $error("Idle or unselected transfer changed the test enable.");

endmodule

//--- pkg/vtr_pkg.sv
package vtr_pkg;
  localparam logic [11:0] OFF_TEST_CTRL   = 12'h300;
  localparam logic [11:0] OFF_CHAIN_IN_RB = 12'h304;
  localparam logic [11:0] OFF_VEC_IN_RB   = 12'h308;
  localparam logic [11:0] OFF_REQ_OUT_RB  = 12'h30C;
  localparam logic [11:0] OFF_VEC_OUT_RB  = 12'h310;
  localparam int unsigned IRQ_BIT         = 7;
  localparam int unsigned FIQ_BIT         = 6;
  localparam int unsigned TEST_EN_BIT     = 0;
  localparam logic        TEST_EN_RST     = 1'h0;
  localparam logic        REQ_N_RST       = 1'h1;
  localparam logic [31:0] WORD_RST        = 32'h0;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  localparam logic [1:0]  HRESP_OKAY      = 2'h0;
  localparam logic [1:0]  HRESP_ERROR     = 2'h1;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        bad;
    logic [11:2] idx;
  } vtr_phase_t;

  typedef struct packed {
    logic        irq_n;
    logic        fiq_n;
    logic [31:0] vec;
  } vtr_chain_t;

  typedef enum {VTR_OK, VTR_ERR_WAIT, VTR_ERR_LAST} vtr_resp_state_t;

  function automatic logic [11:2] vtr_idx(input logic [11:0] off);
    return off[11:2];
  endfunction

  function automatic logic vtr_take(input logic sel, input logic trans1, input logic rdy);
    return sel && trans1 && rdy;
  endfunction

  function automatic logic vtr_mapped(input logic [11:2] idx);
    return idx == vtr_idx(OFF_TEST_CTRL) || idx == vtr_idx(OFF_CHAIN_IN_RB) ||
           idx == vtr_idx(OFF_VEC_IN_RB) || idx == vtr_idx(OFF_REQ_OUT_RB) ||
           idx == vtr_idx(OFF_VEC_OUT_RB);
  endfunction
endpackage

//--- verification/tb_irq_ctrl_test_readback_ahb.sv
`timescale 1ns/1ps
module tb_irq_ctrl_test_readback_ahb
  import vtr_pkg::*;
  ;
  logic        i_clk = 1'h0;
  logic        i_rst_n = 1'h0;
  logic        irq_n = 1'h1, fiq_n = 1'h1, irq = 1'h0, fiq = 1'h0;
  logic [31:0] vin = 32'h0, vnext = 32'h0, rd, wd;
  logic [1:0]  rs;
  logic        sel, tr1, hw, hp1, hrdy, irq_o_n, fiq_o_n, ten;
  logic [2:0]  hsz;
  logic [11:2] ha;
  logic [31:0] hwd, hrd, vout;
  logic [1:0]  hresp;
  logic        m_ten = 1'h0, s_irq_n, s_fiq_n;
  logic [31:0] s_v;
  logic [11:0] offs [5] = '{OFF_TEST_CTRL, OFF_CHAIN_IN_RB, OFF_VEC_IN_RB, OFF_REQ_OUT_RB,
                            OFF_VEC_OUT_RB};
  int          error_cnt = 0, num_checks = 0, cycles = 0, seed = 99;

  always #4 i_clk = ~i_clk;

  vtr_ahb_master vtr_ahb_master_i (.i_clk(i_clk), .i_hready(hrdy), .i_hrdata(hrd),
    .i_hresp(hresp), .o_sel(sel), .o_htrans1(tr1), .o_hwrite(hw), .o_hsize(hsz),
    .o_hprot1(hp1), .o_haddr(ha), .o_hwdata(hwd));

  vtr_test_readback vtr_test_readback_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_slave_select(sel), .i_htrans1(tr1), .i_hwrite(hw), .i_hsize(hsz), .i_hprot1(hp1),
    .i_haddr(ha), .i_hwdata(hwd), .i_hreadyin(hrdy), .o_hrdata(hrd), .o_hreadyout(hrdy),
    .o_hresp(hresp), .i_chained_irq_in_n(irq_n), .i_chained_fiq_in_n(fiq_n),
    .i_chained_vector_address_in(vin), .i_internal_irq_request(irq),
    .i_internal_fiq_request(fiq), .i_vector_address_next(vnext),
    .o_irq_request_out_n(irq_o_n), .o_fiq_request_out_n(fiq_o_n),
    .o_vector_address_out(vout), .o_integration_test_enable(ten));

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
    cmp_word({30'h0, e}, {30'h0, g});
  endtask

  task automatic cmp_pin(input logic e, input logic g);
    cmp_word({31'h0, e}, {31'h0, g});
  endtask

  function automatic logic [31:0] exp_rd(input logic [11:0] off);
    logic [31:0] v;
    v = 32'h0;
    case (off)
      OFF_TEST_CTRL: v[0] = m_ten;
      OFF_CHAIN_IN_RB: begin
        v[IRQ_BIT] = m_ten ? s_irq_n : irq_n;
        v[FIQ_BIT] = m_ten ? s_fiq_n : fiq_n;
      end
      OFF_VEC_IN_RB: v = m_ten ? s_v : vin;
      OFF_REQ_OUT_RB: begin
        v[IRQ_BIT] = irq;
        v[FIQ_BIT] = fiq;
      end
      OFF_VEC_OUT_RB: v = vnext;
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  task automatic acc(input logic wr, input logic [11:0] off, input logic [31:0] d,
                     input logic p1, input logic [2:0] sz, input logic [1:0] ers);
    vtr_ahb_master_i.xfer(1'h1, 1'h1, wr, off, d, sz, p1, rd, rs);
    cmp_resp(ers, rs);
    if (!wr && ers == HRESP_OKAY) begin
      cmp_word(exp_rd(off), rd);
    end
    if (wr && off == OFF_TEST_CTRL && ers == HRESP_OKAY) begin
      // The frozen copy is the pin state when test mode is entered.
      if (!m_ten && d[0]) begin
        s_irq_n = irq_n;
        s_fiq_n = fiq_n;
        s_v = vin;
      end
      m_ten = d[0];
    end
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (2) @(posedge i_clk);
    #1;
    cmp_pin(1'h1, hrdy);
    cmp_resp(HRESP_OKAY, hresp);
    cmp_pin(REQ_N_RST, irq_o_n);
    cmp_word(WORD_RST, vout);
    cmp_pin(TEST_EN_RST, ten);
    i_rst_n = 1'h1;
    acc(1'h0, OFF_CHAIN_IN_RB, 32'h0, 1'h1, HSIZE_WORD, HRESP_OKAY);
    acc(1'h0, OFF_VEC_IN_RB, 32'h0, 1'h1, HSIZE_WORD, HRESP_OKAY);
    for (int k = 0; k < 24; k++) begin
      irq_n = 1'($random(seed));
      fiq_n = 1'($random(seed));
      irq = 1'($random(seed));
      fiq = 1'($random(seed));
      vin = $random(seed);
      vnext = $random(seed);
      if (k == 8 || k == 16) begin
        wd = $random(seed);
        wd[0] = (k == 8);
        acc(1'h1, OFF_TEST_CTRL, wd, 1'h1, HSIZE_WORD, HRESP_OKAY);
        vin = ~vin;
        irq_n = ~irq_n;
      end
      repeat (2) @(posedge i_clk);
      #1;
      cmp_pin(~irq, irq_o_n);
      cmp_pin(~fiq, fiq_o_n);
      cmp_word(vnext, vout);
      cmp_pin(m_ten, ten);
      foreach (offs[j]) begin
        acc(1'h0, offs[j], 32'h0, 1'h1, HSIZE_WORD, HRESP_OKAY);
      end
      acc(1'h1, offs[1 + k % 4], $random(seed), 1'h1, HSIZE_WORD, HRESP_OKAY);
      acc(1'h0, offs[1 + k % 4], 32'h0, 1'h0, HSIZE_WORD, HRESP_OKAY);
    end
    acc(1'h1, OFF_TEST_CTRL, 32'h1, 1'h0, HSIZE_WORD, HRESP_ERROR);
    acc(1'h0, OFF_TEST_CTRL, 32'h0, 1'h0, HSIZE_WORD, HRESP_OKAY);
    acc(1'h0, OFF_VEC_IN_RB, 32'h0, 1'h1, 3'h1, HRESP_ERROR);
    acc(1'h0, 12'h314, 32'h0, 1'h1, HSIZE_WORD, HRESP_ERROR);
    acc(1'h0, 12'h2FC, 32'h0, 1'h1, HSIZE_WORD, HRESP_ERROR);
    vtr_ahb_master_i.xfer(1'h0, 1'h1, 1'h1, OFF_TEST_CTRL, 32'h1, HSIZE_WORD, 1'h1, rd, rs);
    cmp_resp(HRESP_OKAY, rs);
    vtr_ahb_master_i.xfer(1'h1, 1'h0, 1'h1, OFF_TEST_CTRL, 32'h1, HSIZE_WORD, 1'h1, rd, rs);
    cmp_resp(HRESP_OKAY, rs);
    acc(1'h0, OFF_TEST_CTRL, 32'h0, 1'h1, HSIZE_WORD, HRESP_OKAY);
    final_report();
  end
endmodule

//--- verification/vtr_ahb_master.sv
`timescale 1ns/1ps
module vtr_ahb_master
  import vtr_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  input  wire logic [1:0]  i_hresp,
  output logic             o_sel,
  output logic             o_htrans1,
  output logic             o_hwrite,
  output logic      [2:0]  o_hsize,
  output logic             o_hprot1,
  output logic      [11:2] o_haddr,
  output logic      [31:0] o_hwdata
);
  initial begin
    o_sel = 1'h0;
    o_htrans1 = 1'h0;
    o_hwrite = 1'h0;
    o_hsize = HSIZE_WORD;
    o_hprot1 = 1'h1;
    o_haddr = 10'h0;
    o_hwdata = 32'h0;
  end

  task automatic xfer(input logic s, input logic t, input logic wr, input logic [11:0] off,
                      input logic [31:0] wd, input logic [2:0] sz, input logic p1,
                      output logic [31:0] rd, output logic [1:0] rs);
    int n;
    n = 0;
    o_sel <= s;
    o_htrans1 <= t;
    o_hwrite <= wr;
    o_haddr <= off[11:2];
    o_hsize <= sz;
    o_hprot1 <= p1;
    @(posedge i_clk);
    #1;
    // Released lines must not keep showing the old request.
    o_sel <= 1'h0;
    o_htrans1 <= 1'h0;
    o_hwrite <= ~o_hwrite;
    o_haddr <= ~o_haddr;
    o_hprot1 <= ~o_hprot1;
    o_hwdata <= wr ? wd : ~o_hwdata;
    // wait for ready; the answer is taken at that rising edge.
    @(posedge i_clk);
    while (i_hready !== 1'h1 && n < 8) begin
      n++;
      @(posedge i_clk);
    end
    rd = i_hrdata;
    rs = (n == 8) ? 2'h3 : i_hresp;
    #1;
    o_hwdata <= ~o_hwdata;
  endtask
endmodule
